// ==== rtl/afe_regs_pkg.sv ====
// Constants, tables and carrier types for the front-end configuration bank.
// Assumes a 50 MHz register clock and 32-bit AXI4-Lite access.
package afe_regs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] GLOBAL_CONFIG_B_INDEX      = 8'h02;
    localparam logic [7:0] LEAD_DETECT_CONTROL_INDEX  = 8'h03;
    localparam logic [7:0] CHANNEL_ONE_SETTINGS_INDEX = 8'h04;
    localparam logic [7:0] BLOCK_STATUS_INDEX         = 8'h10;

    // Values after reset
    localparam logic [7:0] GLOBAL_CONFIG_B_RESET      = 8'h80;
    localparam logic [7:0] LEAD_DETECT_CONTROL_RESET  = 8'h10;
    localparam logic [7:0] CHANNEL_ONE_SETTINGS_RESET = 8'h00;

    // Global configuration field positions
    localparam int LEAD_COMPARATOR_ENABLE_BIT  = 6;
    localparam int REFERENCE_BUFFER_ENABLE_BIT = 5;
    localparam int HIGH_REFERENCE_SELECT_BIT   = 4;
    localparam int CLOCK_OUT_ENABLE_BIT        = 3;
    localparam int TEST_SIGNAL_ON_BIT          = 1;
    localparam int TEST_WAVE_SELECT_BIT        = 0;

    // Lead detect control field positions
    localparam int COMPARATOR_THRESHOLD_MSB      = 7;
    localparam int COMPARATOR_THRESHOLD_LSB      = 5;
    localparam int EXCITATION_CURRENT_SELECT_MSB = 3;
    localparam int EXCITATION_CURRENT_SELECT_LSB = 2;
    localparam int AC_DETECT_SELECT_BIT          = 0;

    // Channel one field positions
    localparam int CHANNEL_ONE_POWERDOWN_BIT    = 7;
    localparam int CHANNEL_ONE_GAIN_CODE_MSB    = 6;
    localparam int CHANNEL_ONE_GAIN_CODE_LSB    = 4;
    localparam int CHANNEL_ONE_INPUT_SELECT_MSB = 3;
    localparam int CHANNEL_ONE_INPUT_SELECT_LSB = 0;

    // Threshold in tenths of a percent, current in nA, gain as integer
    localparam logic [9:0] POSITIVE_THRESHOLD_PERMILLE [0:7] =
        '{10'h3B6, 10'h39D, 10'h384, 10'h36B, 10'h352, 10'h320, 10'h2EE, 10'h2BC};
    localparam logic [9:0] NEGATIVE_THRESHOLD_PERMILLE [0:7] =
        '{10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h0FA, 10'h12C};
    localparam logic [15:0] EXCITATION_CURRENT_NA [0:3] = '{16'h0006, 16'h0016, 16'h1770, 16'h55F0};
    localparam logic [3:0] CHANNEL_ONE_GAIN [0:7] =
        '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'h0};

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int unsigned CLOCK_PERIOD_NS       = 20;
    localparam int unsigned TEST_HALF_PERIOD_NS   = 500000000;
    localparam int unsigned TEST_HALF_CYCLES      = TEST_HALF_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int unsigned AC_HALF_PERIOD_SAMPLES = 2;

    typedef struct packed {
        logic        lead_comparator_enable;
        logic        reference_buffer_enable;
        logic        high_reference_select;
        logic        clock_out_enable;
        logic        test_signal_on;
        logic        test_signal_high;
        logic        ac_detect_select;
        logic        excitation_phase;
        logic [1:0]  excitation_current_select;
        logic [15:0] excitation_current_na;
        logic [2:0]  comparator_threshold;
        logic [9:0]  positive_threshold_permille;
        logic [9:0]  negative_threshold_permille;
        logic        channel_one_powerdown;
        logic [2:0]  channel_one_gain_code;
        logic [3:0]  channel_one_gain;
        logic [3:0]  channel_one_input_select;
    } afe_controls_t;

endpackage

// ==== rtl/toggle_divider.sv ====
// Phase toggler: flips its output after COUNT ticks while enabled.
// Assumes tick is a one-cycle pulse on the same clock.
module toggle_divider #(
    parameter int unsigned COUNT = 2
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic enable,
    input  wire logic tick,
    output logic      phase
);
    localparam int unsigned CW = (COUNT > 1) ? $clog2(COUNT) : 1;

    logic [CW-1:0] count;
    wire           wrap       = (count == CW'(COUNT - 1));
    wire [CW-1:0]  next_count = wrap ? '0 : CW'(count + 1'b1);

    initial begin
        if (COUNT < 1) begin
            $error("toggle_divider: COUNT must be at least 1");
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            count <= '0;
            phase <= 1'b0;
        end else if (tick) begin
            count <= next_count;
            phase <= wrap ? ~phase : phase;
        end
    end
endmodule

// ==== rtl/afe_config_leadoff_regs.sv ====
// Configuration and lead detect register bank with AXI4-Lite access.
// Assumes data_ready comes from logic on aclk; internal_osc_pin is an external strap.
module afe_config_leadoff_regs
    import afe_regs_pkg::*;
#(
    parameter int unsigned ADDR_W     = 8,
    parameter int unsigned TEST_HALF  = TEST_HALF_CYCLES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              internal_osc_pin,
    input  wire logic              data_ready,
    output afe_controls_t          controls
);
    localparam int unsigned IDX_W = ADDR_W - 2;

    // Refuse sizes the decode cannot serve
    initial begin
        if (ADDR_W < 7 || ADDR_W > 32) begin
            $error("afe_config_leadoff_regs: ADDR_W must lie between 7 and 32");
        end
        if (TEST_HALF < 1) begin
            $error("afe_config_leadoff_regs: TEST_HALF must be at least 1");
        end
    end

    // One-hot write and read states
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

    wr_state_t         wr_state;
    wr_state_t         next_wr_state;
    rd_state_t         rd_state;
    rd_state_t         next_rd_state;

    // Register contents
    logic [7:0]        global_config_b;
    logic [7:0]        lead_detect_control;
    logic [7:0]        channel_one_settings;

    // A half that came alone
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_held;
    logic [7:0]        w_data_q;
    logic              w_lane_q;

    // Strap synchroniser stages
    logic [2:0]        osc_sync;
    logic              osc_level;

    // Square and ac phases
    logic              test_phase;
    logic              excitation_toggle;

    // Write channel handshakes and the combined transfer
    wire               aw_fire   = awvalid && awready;
    wire               w_fire    = wvalid && wready;
    wire               in_collect = (wr_state == WR_COLLECT);
    wire               have_addr = aw_held || aw_fire;
    wire               have_data = w_held || w_fire;
    wire               commit    = in_collect && have_addr && have_data;

    wire [ADDR_W-1:0]  wr_addr   = aw_fire ? awaddr : aw_addr_q;
    wire [7:0]         wr_byte   = w_fire ? wdata[7:0] : w_data_q;
    wire               wr_lane   = w_fire ? wstrb[0] : w_lane_q;
    wire [IDX_W-1:0]   wr_index  = wr_addr[ADDR_W-1:2];
    wire               wr_align  = (wr_addr[1:0] == 2'h0);

    // Write address decode
    wire               wr_global  = wr_align && (wr_index == IDX_W'(GLOBAL_CONFIG_B_INDEX));
    wire               wr_lead    = wr_align && (wr_index == IDX_W'(LEAD_DETECT_CONTROL_INDEX));
    wire               wr_channel = wr_align && (wr_index == IDX_W'(CHANNEL_ONE_SETTINGS_INDEX));
    wire               wr_known   = wr_global || wr_lead || wr_channel;
    wire [1:0]         next_bresp = wr_known ? RESP_OKAY : RESP_SLVERR;

    wire               load_global  = commit && wr_global && wr_lane;
    wire               load_lead    = commit && wr_lead && wr_lane;
    wire               load_channel = commit && wr_channel && wr_lane;

    wire [7:0]         next_global  = load_global ? wr_byte : global_config_b;
    wire [7:0]         next_lead    = load_lead ? wr_byte : lead_detect_control;
    wire [7:0]         next_channel = load_channel ? wr_byte : channel_one_settings;

    wire               b_done        = bvalid && bready;
    wire               next_aw_held  = in_collect && !commit && have_addr;
    wire               next_w_held   = in_collect && !commit && have_data;

    // Collect both halves, then answer
    always_comb begin
        next_wr_state = wr_state;
        unique case (wr_state)
            WR_COLLECT: begin
                if (commit) begin
                    next_wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (b_done) begin
                    next_wr_state = WR_COLLECT;
                end
            end
            default: begin
                next_wr_state = WR_COLLECT;
            end
        endcase
    end

    // Readies drop while a half is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= WR_COLLECT;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            awready  <= (next_wr_state == WR_COLLECT) && !next_aw_held;
            wready   <= (next_wr_state == WR_COLLECT) && !next_w_held;
            bvalid   <= commit || (bvalid && !bready);
            bresp    <= commit ? next_bresp : bresp;
        end
    end

    // Capture a lone half
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= '0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
        end else begin
            aw_addr_q <= aw_fire ? awaddr : aw_addr_q;
            w_data_q  <= w_fire ? wdata[7:0] : w_data_q;
            w_lane_q  <= w_fire ? wstrb[0] : w_lane_q;
        end
    end

    // Register storage, defaults on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_config_b      <= GLOBAL_CONFIG_B_RESET;
            lead_detect_control  <= LEAD_DETECT_CONTROL_RESET;
            channel_one_settings <= CHANNEL_ONE_SETTINGS_RESET;
        end else begin
            global_config_b      <= next_global;
            lead_detect_control  <= next_lead;
            channel_one_settings <= next_channel;
        end
    end

    // Read path
    wire               ar_fire    = arvalid && arready;
    wire [IDX_W-1:0]   rd_index   = araddr[ADDR_W-1:2];
    wire               rd_align   = (araddr[1:0] == 2'h0);
    wire               rd_global  = rd_align && (rd_index == IDX_W'(GLOBAL_CONFIG_B_INDEX));
    wire               rd_lead    = rd_align && (rd_index == IDX_W'(LEAD_DETECT_CONTROL_INDEX));
    wire               rd_channel = rd_align && (rd_index == IDX_W'(CHANNEL_ONE_SETTINGS_INDEX));
    wire               rd_status  = rd_align && (rd_index == IDX_W'(BLOCK_STATUS_INDEX));
    wire               rd_known   = rd_global || rd_lead || rd_channel || rd_status;

    // Status: clock out, strap, ac and test phases
    wire [7:0]         status_byte = {4'h0, controls.clock_out_enable, osc_level,
                                      excitation_toggle, test_phase};

    wire [7:0]         rd_byte = rd_global  ? global_config_b :
                                 rd_lead    ? lead_detect_control :
                                 rd_channel ? channel_one_settings :
                                 rd_status  ? status_byte : 8'h00;
    wire [1:0]         next_rresp = rd_known ? RESP_OKAY : RESP_SLVERR;
    wire               r_done     = rvalid && rready;

    // One read at a time
    always_comb begin
        next_rd_state = rd_state;
        unique case (rd_state)
            RD_IDLE: begin
                if (ar_fire) begin
                    next_rd_state = RD_DATA;
                end
            end
            RD_DATA: begin
                if (r_done) begin
                    next_rd_state = RD_IDLE;
                end
            end
            default: begin
                next_rd_state = RD_IDLE;
            end
        endcase
    end

    // Read data taken with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            arready  <= 1'b0;
            rvalid   <= 1'b0;
            rdata    <= 32'h00000000;
            rresp    <= RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            arready  <= (next_rd_state == RD_IDLE);
            rvalid   <= (next_rd_state == RD_DATA);
            rdata    <= ar_fire ? {24'h000000, rd_byte} : rdata;
            rresp    <= ar_fire ? next_rresp : rresp;
        end
    end

    // Strap synchroniser: level changes once second and third stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_sync  <= 3'h0;
            osc_level <= 1'b0;
        end else begin
            osc_sync  <= {osc_sync[1:0], internal_osc_pin};
            osc_level <= (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_level;
        end
    end

    // Field extraction from next values,
    // so controls follow a write at once
    wire       f_comp_en   = next_global[LEAD_COMPARATOR_ENABLE_BIT];
    wire       f_refbuf    = next_global[REFERENCE_BUFFER_ENABLE_BIT];
    wire       f_high_ref  = next_global[HIGH_REFERENCE_SELECT_BIT];
    wire       f_clk_out   = next_global[CLOCK_OUT_ENABLE_BIT];
    wire       f_test_on   = next_global[TEST_SIGNAL_ON_BIT];
    wire       f_test_wave = next_global[TEST_WAVE_SELECT_BIT];
    wire [2:0] f_threshold = next_lead[COMPARATOR_THRESHOLD_MSB:COMPARATOR_THRESHOLD_LSB];
    wire [1:0] f_current   = next_lead[EXCITATION_CURRENT_SELECT_MSB:EXCITATION_CURRENT_SELECT_LSB];
    wire       f_ac_detect = next_lead[AC_DETECT_SELECT_BIT];
    wire       f_ch_pd     = next_channel[CHANNEL_ONE_POWERDOWN_BIT];
    wire [2:0] f_gain_code = next_channel[CHANNEL_ONE_GAIN_CODE_MSB:CHANNEL_ONE_GAIN_CODE_LSB];
    wire [3:0] f_input_sel = next_channel[CHANNEL_ONE_INPUT_SELECT_MSB:CHANNEL_ONE_INPUT_SELECT_LSB];

    // Test wave and ac excitation phase generators
    toggle_divider #(
        .COUNT (TEST_HALF)
    ) test_wave_gen (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (global_config_b[TEST_SIGNAL_ON_BIT] && global_config_b[TEST_WAVE_SELECT_BIT]),
        .tick    (1'b1),
        .phase   (test_phase)
    );

    toggle_divider #(
        .COUNT (AC_HALF_PERIOD_SAMPLES)
    ) excitation_gen (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (lead_detect_control[AC_DETECT_SELECT_BIT]),
        .tick    (data_ready),
        .phase   (excitation_toggle)
    );

    // Decoded controls
    wire        next_clock_out = f_clk_out && osc_level;
    wire        next_test_high = f_test_on && (f_test_wave ? test_phase : 1'b1);
    wire        next_exc_phase = f_ac_detect ? excitation_toggle : 1'b0;
    wire [9:0]  next_pos_th    = POSITIVE_THRESHOLD_PERMILLE[f_threshold];
    wire [9:0]  next_neg_th    = NEGATIVE_THRESHOLD_PERMILLE[f_threshold];
    wire [15:0] next_current   = EXCITATION_CURRENT_NA[f_current];
    wire [3:0]  next_gain      = CHANNEL_ONE_GAIN[f_gain_code];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Every field at its default
            controls <= '0;
            controls.positive_threshold_permille <= POSITIVE_THRESHOLD_PERMILLE[0];
            controls.negative_threshold_permille <= NEGATIVE_THRESHOLD_PERMILLE[0];
            controls.excitation_current_na       <= EXCITATION_CURRENT_NA[0];
            controls.channel_one_gain            <= CHANNEL_ONE_GAIN[0];
        end else begin
            // Global configuration
            controls.lead_comparator_enable      <= f_comp_en;
            controls.reference_buffer_enable     <= f_refbuf;
            controls.high_reference_select       <= f_high_ref;
            controls.clock_out_enable            <= next_clock_out;
            controls.test_signal_on              <= f_test_on;
            controls.test_signal_high            <= next_test_high;

            // Lead detect control
            controls.ac_detect_select            <= f_ac_detect;
            controls.excitation_phase            <= next_exc_phase;
            controls.excitation_current_select   <= f_current;
            controls.excitation_current_na       <= next_current;
            controls.comparator_threshold        <= f_threshold;
            controls.positive_threshold_permille <= next_pos_th;
            controls.negative_threshold_permille <= next_neg_th;

            // Channel one
            controls.channel_one_powerdown       <= f_ch_pd;
            controls.channel_one_gain_code       <= f_gain_code;
            controls.channel_one_gain            <= next_gain;
            controls.channel_one_input_select    <= f_input_sel;
        end
    end
endmodule

// ==== tb/afe_config_leadoff_regs_properties.sv ====
// Port checker for the configuration register bank.
// Assumes one aclk domain with synchronous active-low reset.
module afe_config_leadoff_regs_properties
    import afe_regs_pkg::*;
#(
    parameter int unsigned ADDR_W    = 8,
    parameter int unsigned TEST_HALF = TEST_HALF_CYCLES
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic [31:0]       wdata,
    input wire logic [3:0]        wstrb,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic [1:0]        bresp,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    input wire logic              rvalid,
    input wire logic              rready,
    input afe_controls_t          controls
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_wr(a);
        s_take ##0 wstrb[0] && awaddr == a;
    endsequence
    a_write_answer:
        assert property (s_take |=> bvalid) else $error("write response late");
    a_resp_hold:
        assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
    a_read_answer:
        assert property (arvalid && arready |=> rvalid) else $error("read response late");
    a_read_hold:
        assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
    a_unmapped_err:
        assert property (s_take ##0 awaddr == 'h14 |=> bresp == RESP_SLVERR) else $error("unmapped write accepted");
    a_read_upper:
        assert property (arvalid && arready && araddr == 'h08 |=> rresp == RESP_OKAY && rdata[31:8] == 24'h0)
            else $error("mapped read bad");
    a_global_fields:
        assert property (s_wr('h08) |-> ##2 {controls.lead_comparator_enable, controls.reference_buffer_enable,
            controls.high_reference_select, controls.test_signal_on} == {$past(wdata[6:4], 2), $past(wdata[1], 2)})
            else $error("global fields wrong");
    a_lead_fields:
        assert property (s_wr('h0C) |-> ##2 {controls.comparator_threshold, controls.excitation_current_select,
            controls.ac_detect_select} == {$past(wdata[7:5], 2), $past(wdata[3:2], 2), $past(wdata[0], 2)})
            else $error("lead fields wrong");
    a_channel_fields:
        assert property (s_wr('h10) |-> ##2 {controls.channel_one_powerdown, controls.channel_one_gain_code,
            controls.channel_one_input_select} == $past(wdata[7:0], 2)) else $error("channel fields wrong");
    a_code_maps:
        assert property (controls.positive_threshold_permille ==
            POSITIVE_THRESHOLD_PERMILLE[controls.comparator_threshold]
            && controls.negative_threshold_permille == NEGATIVE_THRESHOLD_PERMILLE[controls.comparator_threshold]
            && controls.excitation_current_na == EXCITATION_CURRENT_NA[controls.excitation_current_select]
            && controls.channel_one_gain == CHANNEL_ONE_GAIN[controls.channel_one_gain_code])
            else $error("code map wrong");
    a_test_off:
        assert property (!controls.test_signal_on [*2] |-> !controls.test_signal_high) else $error("test signal on");
    a_dc_phase:
        assert property (!controls.ac_detect_select [*2] |-> !controls.excitation_phase) else $error("dc phase moves");
endmodule

bind afe_config_leadoff_regs afe_config_leadoff_regs_properties #(.ADDR_W(ADDR_W), .TEST_HALF(TEST_HALF)) i_props (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .controls);

// ==== tb/afe_config_leadoff_regs_bench.sv ====
// Self-checking bench for the configuration register bank.
// Assumes a 50 MHz clock; the bench is the AXI4-Lite master.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module afe_config_leadoff_regs_bench import afe_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic          aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic          arvalid = 1'b0, rready = 1'b0, internal_osc_pin = 1'b0, data_ready = 1'b0;
    logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]   wdata = 32'h0, rdata;
    logic [3:0]    wstrb = 4'h0;
    logic          awready, wready, bvalid, arready, rvalid;
    logic [1:0]    bresp, rresp;
    afe_controls_t controls;
    int            n_fail = 0, n_compared = 0;
    logic [9:0]    pos_t [8] = '{10'h3B6, 10'h39D, 10'h384, 10'h36B, 10'h352, 10'h320, 10'h2EE, 10'h2BC};
    logic [9:0]    neg_t [8] = '{10'h032, 10'h04B, 10'h064, 10'h07D, 10'h096, 10'h0C8, 10'h0FA, 10'h12C};
    logic [15:0]   cur_t [4] = '{16'h0006, 16'h0016, 16'h1770, 16'h55F0};
    logic [3:0]    gain_t [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'h0};
    always #10 aclk = ~aclk;
    afe_config_leadoff_regs #(.ADDR_W(8), .TEST_HALF(8)) i_afe_config_leadoff_regs (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .internal_osc_pin, .data_ready, .controls);
    task automatic summarize;
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic hang;
        n_fail++;
        $display("ERROR handshake exp answer got none");
        summarize();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n > 50) hang();
        end while (!bvalid);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n > 50) hang();
        end while (!rvalid);
        rready <= 1'b0;
        `CHK("rdata", {24'h0, ed}, rdata)
        `CHK("rresp", er, rresp)
        tick(1);
    endtask
    task automatic pulse;
        data_ready <= 1'b1;
        tick(1);
        data_ready <= 1'b0;
        tick(1);
    endtask
    initial begin
        tick(10);
        aresetn <= 1'b1;
        tick(1);
        rd(8'h08, 8'h80, RESP_OKAY);
        rd(8'h0C, 8'h10, RESP_OKAY);
        rd(8'h10, 8'h00, RESP_OKAY);
        `CHK("defaults", {10'h3B6, 10'h032, 16'h0006, 4'h6, 1'b0},
            {controls.positive_threshold_permille, controls.negative_threshold_permille,
            controls.excitation_current_na, controls.channel_one_gain, controls.lead_comparator_enable})
        for (int c = 0; c < 8; c++) begin
            wr(8'h0C, {c[2:0], 5'h10}, 4'h1, RESP_OKAY);
            tick(1);
            `CHK("pos thr", pos_t[c], controls.positive_threshold_permille)
            `CHK("neg thr", neg_t[c], controls.negative_threshold_permille)
            rd(8'h0C, {c[2:0], 5'h10}, RESP_OKAY);
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h0C, {4'h1, c[1:0], 2'h0}, 4'h1, RESP_OKAY);
            tick(1);
            `CHK("current", cur_t[c], controls.excitation_current_na)
        end
        wr(8'h10, 8'h01, 4'h1, RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            wr(8'h10, {1'b1, c[2:0], 4'h1}, 4'h1, RESP_OKAY);
            tick(1);
            `CHK("gain", {1'b1, gain_t[c], 4'h1}, {controls.channel_one_powerdown,
                controls.channel_one_gain, controls.channel_one_input_select})
            rd(8'h10, {1'b1, c[2:0], 4'h1}, RESP_OKAY);
        end
        wr(8'h08, 8'hF2, 4'h1, RESP_OKAY);
        tick(1);
        `CHK("global on", 5'h1F, {controls.lead_comparator_enable, controls.reference_buffer_enable,
            controls.high_reference_select, controls.test_signal_on, controls.test_signal_high})
        wr(8'h08, 8'h80, 4'h1, RESP_OKAY);
        tick(1);
        `CHK("global off", 5'h00, {controls.lead_comparator_enable, controls.reference_buffer_enable,
            controls.high_reference_select, controls.test_signal_on, controls.test_signal_high})
        wr(8'h08, 8'h83, 4'h1, RESP_OKAY);
        tick(2);
        `CHK("square low", 1'b0, controls.test_signal_high)
        tick(8);
        `CHK("square high", 1'b1, controls.test_signal_high)
        tick(8);
        `CHK("square fall", 1'b0, controls.test_signal_high)
        internal_osc_pin <= 1'b1;
        wr(8'h08, 8'h88, 4'h1, RESP_OKAY);
        tick(8);
        `CHK("clk out on", 1'b1, controls.clock_out_enable)
        internal_osc_pin <= 1'b0;
        tick(8);
        `CHK("clk out ext", 1'b0, controls.clock_out_enable)
        internal_osc_pin <= 1'b1;
        wr(8'h08, 8'h80, 4'h1, RESP_OKAY);
        tick(8);
        `CHK("clk out off", 1'b0, controls.clock_out_enable)
        wr(8'h0C, 8'h11, 4'h1, RESP_OKAY);
        tick(1);
        `CHK("ac start", 1'b0, controls.excitation_phase)
        repeat (2) pulse();
        tick(2);
        `CHK("ac half", 1'b1, controls.excitation_phase)
        repeat (2) pulse();
        tick(2);
        `CHK("ac full", 1'b0, controls.excitation_phase)
        wr(8'h0C, 8'h10, 4'h1, RESP_OKAY);
        wr(8'h10, 8'h55, 4'h0, RESP_OKAY);
        wr(8'h14, 8'hFF, 4'h1, RESP_SLVERR);
        wr(8'h09, 8'hFF, 4'h1, RESP_SLVERR);
        wr(8'h40, 8'hFF, 4'h1, RESP_SLVERR);
        rd(8'h18, 8'h00, RESP_SLVERR);
        rd(8'h40, 8'h04, RESP_OKAY);
        rd(8'h10, 8'hF1, RESP_OKAY);
        aresetn <= 1'b0;
        tick(3);
        aresetn <= 1'b1;
        tick(1);
        rd(8'h10, 8'h00, RESP_OKAY);
        rd(8'h08, 8'h80, RESP_OKAY);
        summarize();
    end
endmodule
